// File: cjb_decode.sv
// combinational decoder of the three compact instruction formats
`timescale 1ns/10ps
module cjb_decode (
	input wire logic [15:0] instr,
	output cjb_pkg::cjb_op_t op,
	output logic [4:0] field_hi5,
	output logic [4:0] dest_reg,
	output logic [4:0] base_reg,
	output logic [63:0] load_offset
);
	import cjb_pkg::*;
	function automatic logic [4:0] map3(input logic [2:0] f);
		map3 = (f < 3'h2) ? {4'h8, f[0]} : {2'h0, f};
	endfunction
	always_comb begin
		op = CJB_OP_NONE;
		field_hi5 = instr[9:5];
		dest_reg = map3(instr[9:7]);
		base_reg = map3(instr[6:4]);
		if (instr[3:0] == OFFSET_MINUS_ONE_CODE) begin
			load_offset = '1;
		end else begin
			load_offset = {60'h0, instr[3:0]};
		end
		if (instr[OP_HI:OP_LO] == MAJ_COMPACT_GROUP) begin
			if (instr[4:0] == SUB_JUMP_STACK) begin
				op = CJB_OP_JRSP;
			end else if (instr[4:0] == SUB_JUMP_REG) begin
				op = CJB_OP_JR;
			end else if (instr[4:0] == SUB_JUMP_LINK) begin
				op = CJB_OP_JALR;
			end
		end else if (instr[OP_HI:OP_LO] == MAJ_BYTE_LOAD) begin
			op = CJB_OP_LBU;
		end
	end
endmodule

// File: cjb_exec.sv
// execute stage for compact register jumps and the short byte load
`timescale 1ns/10ps
module cjb_exec #(
	parameter bit FULL_WIDTH_SET = 1'b1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [63:0] instr_pc,
	input wire logic [1:0] config_instr_set_field,
	input wire logic big_endian,
	input wire logic reverse_endian,
	output logic [4:0] rf_rd_addr_a,
	output logic [4:0] rf_rd_addr_b,
	input wire logic [63:0] rf_rd_data_a,
	input wire logic [63:0] rf_rd_data_b,
	output logic instr_ready,
	output logic rf_wr_en,
	output logic [4:0] rf_wr_addr,
	output logic [63:0] rf_wr_data,
	output logic redirect,
	output logic [63:0] redirect_pc,
	output logic instr_set_mode_bit,
	output logic fetch_addr_error,
	output logic squash_next,
	output logic irq_hold,
	output logic mem_rd_en,
	output logic [63:0] mem_addr,
	input wire logic mem_rd_valid,
	input wire logic [63:0] mem_rd_data
);
	import cjb_pkg::*;
	cjb_op_t op;
	logic [4:0] field_hi5, dest_reg, base_reg;
	logic [63:0] load_offset;
	cjb_state_t state, next_state;
	logic [4:0] load_dest, next_load_dest;
	logic [2:0] load_lane, next_load_lane;
	logic next_instr_ready, next_rf_wr_en, next_redirect;
	logic [4:0] next_rf_wr_addr;
	logic [63:0] next_rf_wr_data, next_redirect_pc, next_mem_addr;
	logic next_mode, next_fault, next_squash, next_irq_hold, next_mem_rd_en;
	logic [63:0] target, ea;
	logic [31:0] sp_sum;
	logic take;
	logic [2:0] word_lane, read_lane;

	cjb_decode u_dec (
		.instr(instr),
		.op(op),
		.field_hi5(field_hi5),
		.dest_reg(dest_reg),
		.base_reg(base_reg),
		.load_offset(load_offset)
	);

	function automatic logic is_jump(input cjb_op_t o);
		is_jump = (o == CJB_OP_JR) || (o == CJB_OP_JALR) ||
			(o == CJB_OP_JRSP);
	endfunction

	function automatic logic [2:0] lane_swap(input logic [2:0] a,
		input logic flip);
		lane_swap = a ^ {3{flip}};
	endfunction

	// the stack-adjust jump carries an immediate, its target is the link
	always_comb begin
		if (op == CJB_OP_LBU) begin
			rf_rd_addr_a = base_reg;
		end else if (op == CJB_OP_JRSP) begin
			rf_rd_addr_a = REG_LINK;
		end else begin
			rf_rd_addr_a = field_hi5;
		end
		rf_rd_addr_b = REG_STACK;
	end

	// operands shared by the three groups below
	always_comb begin
		take = instr_valid && instr_ready && (state == CJB_IDLE);
		target = rf_rd_data_a;
		// 32-bit wrap, no overflow check; assumed
		sp_sum = rf_rd_data_b[31:0] + {25'h0, field_hi5, 2'h0};
		ea = rf_rd_data_a + load_offset;
		word_lane = lane_swap(ea[2:0], reverse_endian);
		read_lane = lane_swap(ea[2:0], big_endian);
	end

	// jump group: redirect, mode, fault, squash and interrupt hold
	always_comb begin
		next_redirect = 1'b0;
		next_redirect_pc = redirect_pc;
		next_mode = instr_set_mode_bit;
		next_fault = 1'b0;
		next_squash = 1'b0;
		next_irq_hold = 1'b0;
		if (take && is_jump(op)) begin
			next_redirect = 1'b1;
			next_squash = 1'b1;
			next_irq_hold = (op == CJB_OP_JRSP);
			if (config_instr_set_field == CFG_COMPRESSED_ONLY) begin
				next_redirect_pc = target;
			end else begin
				next_redirect_pc = {target[63:1], 1'b0};
				if (FULL_WIDTH_SET) begin
					next_mode = target[0];
					next_fault = !target[0] && target[1];
				end else begin
					// only the compressed set exists on this core
					next_mode = 1'b1;
					next_fault = !target[0];
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			redirect <= 1'b0;
			redirect_pc <= 64'h0;
			instr_set_mode_bit <= 1'b1;
			fetch_addr_error <= 1'b0;
			squash_next <= 1'b0;
			irq_hold <= 1'b0;
		end else begin
			redirect <= next_redirect;
			redirect_pc <= next_redirect_pc;
			instr_set_mode_bit <= next_mode;
			fetch_addr_error <= next_fault;
			squash_next <= next_squash;
			irq_hold <= next_irq_hold;
		end
	end

	// load group: sequencer, memory request and the lane to return
	always_comb begin
		next_state = state;
		next_load_dest = load_dest;
		next_load_lane = load_lane;
		next_instr_ready = instr_ready;
		next_mem_rd_en = 1'b0;
		next_mem_addr = mem_addr;
		case (state)
			CJB_IDLE: begin
				next_instr_ready = 1'b1;
				if (take && op == CJB_OP_LBU) begin
					next_mem_rd_en = 1'b1;
					next_mem_addr = {ea[63:3], word_lane};
					next_load_lane = read_lane;
					next_load_dest = dest_reg;
					// nothing new is taken until the byte is back
					next_instr_ready = 1'b0;
					next_state = CJB_LOAD_WAIT;
				end
			end
			CJB_LOAD_WAIT: begin
				next_instr_ready = 1'b0;
				if (mem_rd_valid) begin
					next_instr_ready = 1'b1;
					next_state = CJB_IDLE;
				end
			end
			default: begin
				next_instr_ready = 1'b1;
				next_state = CJB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= CJB_IDLE;
			load_dest <= 5'h00;
			load_lane <= 3'h0;
			instr_ready <= 1'b1;
			mem_rd_en <= 1'b0;
			mem_addr <= 64'h0;
		end else begin
			state <= next_state;
			load_dest <= next_load_dest;
			load_lane <= next_load_lane;
			instr_ready <= next_instr_ready;
			mem_rd_en <= next_mem_rd_en;
			mem_addr <= next_mem_addr;
		end
	end

	// write-back group: link, stack pointer and the loaded byte
	always_comb begin
		next_rf_wr_en = 1'b0;
		next_rf_wr_addr = rf_wr_addr;
		next_rf_wr_data = rf_wr_data;
		if (take && op == CJB_OP_JALR) begin
			next_rf_wr_en = 1'b1;
			next_rf_wr_addr = REG_LINK;
			next_rf_wr_data = instr_pc + INSTR_LEN;
		end else if (take && op == CJB_OP_JRSP) begin
			next_rf_wr_en = 1'b1;
			next_rf_wr_addr = REG_STACK;
			next_rf_wr_data = {{32{sp_sum[31]}}, sp_sum};
		end else if (state == CJB_LOAD_WAIT && mem_rd_valid) begin
			next_rf_wr_en = 1'b1;
			next_rf_wr_addr = load_dest;
			next_rf_wr_data = {56'h0, mem_rd_data[{load_lane, 3'h0} +: 8]};
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rf_wr_en <= 1'b0;
			rf_wr_addr <= 5'h00;
			rf_wr_data <= 64'h0;
		end else begin
			rf_wr_en <= next_rf_wr_en;
			rf_wr_addr <= next_rf_wr_addr;
			rf_wr_data <= next_rf_wr_data;
		end
	end
endmodule

// File: cjb_exec_sva.sv
// checker on the ports of the compact jump and byte load execute block
`timescale 1ns/10ps
module cjb_exec_sva import cjb_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [15:0] instr,
	input wire logic redirect,
	input wire logic squash_next,
	input wire logic irq_hold,
	input wire logic rf_wr_en,
	input wire logic [4:0] rf_wr_addr,
	input wire logic mem_rd_en,
	input wire logic mem_rd_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire tk = instr_valid && instr_ready;
	wire jg = tk && instr[15:10] == MAJ_COMPACT_GROUP;
	chk_jr_plain: assert property (jg && instr[4:0] == SUB_JUMP_REG
		|=> redirect && !irq_hold) else $error("plain jump lost");
	chk_jr_stack: assert property (jg && instr[4:0] == SUB_JUMP_STACK
		|=> irq_hold && rf_wr_en && rf_wr_addr == REG_STACK)
		else $error("stack jump wrong");
	chk_jr_link: assert property (jg && instr[4:0] == SUB_JUMP_LINK
		|=> rf_wr_en && rf_wr_addr == REG_LINK) else $error("no link");
	chk_no_slot: assert property (redirect |-> squash_next)
		else $error("next not squashed");
	chk_follow_any: assert property (jg |=> instr_ready)
		else $error("not ready after jump");
	chk_load_start: assert property (tk && instr[15:10] == MAJ_BYTE_LOAD
		|=> mem_rd_en && !instr_ready ##1 !mem_rd_en)
		else $error("load not started");
	chk_load_done: assert property (mem_rd_valid && !instr_ready
		|=> rf_wr_en && instr_ready) else $error("load not written");
	chk_load_regs: assert property (rf_wr_en && !redirect
		|-> rf_wr_addr inside {[5'h2:5'h7], 5'h10, 5'h11})
		else $error("load register out of set");
	cover property (redirect && squash_next);
	cover property (irq_hold);
	cover property (mem_rd_valid && !instr_ready);
endmodule
bind cjb_exec cjb_exec_sva u_sva (
	.clock(clock),
	.rst_n(rst_n),
	.instr_valid(instr_valid),
	.instr_ready(instr_ready),
	.instr(instr),
	.redirect(redirect),
	.squash_next(squash_next),
	.irq_hold(irq_hold),
	.rf_wr_en(rf_wr_en),
	.rf_wr_addr(rf_wr_addr),
	.mem_rd_en(mem_rd_en),
	.mem_rd_valid(mem_rd_valid)
);

// File: cjb_far.sv
// far side: register file read ports and data memory with set latency
`timescale 1ns/10ps
module cjb_far (
	input wire logic clock,
	input wire logic [4:0] rf_rd_addr_a,
	input wire logic [4:0] rf_rd_addr_b,
	output logic [63:0] rf_rd_data_a,
	output logic [63:0] rf_rd_data_b,
	input wire logic mem_rd_en,
	output logic mem_rd_valid,
	output logic [63:0] mem_rd_data
);
	localparam logic [63:0] PAT = 64'h8877665544332211;
	logic [63:0] gpr [32];
	int lat = 1;
	int cnt = 0;
	assign rf_rd_data_a = gpr[rf_rd_addr_a];
	assign rf_rd_data_b = gpr[rf_rd_addr_b];
	// inverse pattern while no read data stands
	assign mem_rd_data = mem_rd_valid ? PAT : ~PAT;
	initial mem_rd_valid = 1'h0;
	always @(posedge clock) begin
		mem_rd_valid <= cnt == 1;
		cnt <= mem_rd_en ? lat : (cnt > 0 ? cnt - 1 : 0);
	end
endmodule

// File: cjb_pkg.sv
// constants and types for the compact jump and byte load execute block
// What this block does
// - stack-adjust jump: group 010001, low 10011
// - plain register jump: group 010001, low 00011
// - byte load: major 000010, rd/base/offset fields
// - no full-width set: bit0 zero faults
// - full-width set: mode from bit0, check alignment
// - stack pointer plus immediate times four, sign-extended
// - stack update never signals overflow
// - compact jumps squash the following instruction
// - any instruction may follow a compact jump
// - interrupts are held off during stack-adjust jump
// - offset code f means -1, else 0..14
// - address is base plus offset, byte zero-extended
// - 3-bit fields map to registers 2-7,16,17
// - linking jump writes return address to register 31
package cjb_pkg;
	localparam int XLEN = 64;
	localparam logic [5:0] MAJ_COMPACT_GROUP = 6'h11;
	localparam logic [5:0] MAJ_BYTE_LOAD = 6'h02;
	localparam logic [4:0] SUB_JUMP_REG = 5'h03;
	localparam logic [4:0] SUB_JUMP_LINK = 5'h0B;
	localparam logic [4:0] SUB_JUMP_STACK = 5'h13;
	localparam logic [4:0] REG_STACK = 5'h1D;
	localparam logic [4:0] REG_LINK = 5'h1F;
	localparam logic [1:0] CFG_COMPRESSED_ONLY = 2'h1;
	localparam logic [3:0] OFFSET_MINUS_ONE_CODE = 4'hF;
	localparam logic [63:0] INSTR_LEN = 64'h2;
	localparam int OP_HI = 15;
	localparam int OP_LO = 10;
	typedef enum logic [2:0] {
		CJB_OP_NONE, CJB_OP_JR, CJB_OP_JALR, CJB_OP_JRSP, CJB_OP_LBU
	} cjb_op_t;
	typedef enum logic [1:0] {CJB_IDLE, CJB_LOAD_WAIT} cjb_state_t;
endpackage

// File: test_compact_jump_and_byte_load_exec.sv
// self-checking bench for the compact jump and byte load execute block
`timescale 1ns/10ps
module test_compact_jump_and_byte_load_exec;
	import cjb_pkg::*;
	logic clock = 1'h0, rst_n = 1'h0, instr_valid = 1'h0;
	logic [15:0] instr = 16'h0;
	logic [63:0] instr_pc = 64'h0;
	logic [1:0] config_instr_set_field = 2'h0;
	logic big_endian = 1'h0, reverse_endian = 1'h0;
	logic [4:0] rf_rd_addr_a, rf_rd_addr_b, rf_wr_addr;
	logic [63:0] rf_rd_data_a, rf_rd_data_b, rf_wr_data, redirect_pc;
	logic [63:0] mem_addr, mem_rd_data;
	logic instr_ready, rf_wr_en, redirect, instr_set_mode_bit;
	logic fetch_addr_error, squash_next, irq_hold, mem_rd_en, mem_rd_valid;
	logic [63:0] n_redirect_pc;
	logic n_mode, n_fault;
	int fail_count = 0, n_compared = 0, cyc = 0;
	cjb_exec dut (.clock, .rst_n, .instr_valid, .instr, .instr_pc,
		.config_instr_set_field, .big_endian, .reverse_endian,
		.rf_rd_addr_a, .rf_rd_addr_b, .rf_rd_data_a, .rf_rd_data_b,
		.instr_ready, .rf_wr_en, .rf_wr_addr, .rf_wr_data, .redirect,
		.redirect_pc, .instr_set_mode_bit, .fetch_addr_error, .squash_next,
		.irq_hold, .mem_rd_en, .mem_addr, .mem_rd_valid, .mem_rd_data);
	cjb_far far (.clock, .rf_rd_addr_a, .rf_rd_addr_b, .rf_rd_data_a,
		.rf_rd_data_b, .mem_rd_en, .mem_rd_valid, .mem_rd_data);
	// core without the full-width set, watched for its mode, fault and redirect target only
	cjb_exec #(.FULL_WIDTH_SET(1'b0)) dut_narrow (.clock, .rst_n,
		.instr_valid, .instr, .instr_pc, .config_instr_set_field,
		.big_endian, .reverse_endian, .rf_rd_addr_a(), .rf_rd_addr_b(),
		.rf_rd_data_a, .rf_rd_data_b, .instr_ready(), .rf_wr_en(),
		.rf_wr_addr(), .rf_wr_data(), .redirect(),
		.redirect_pc(n_redirect_pc), .instr_set_mode_bit(n_mode),
		.fetch_addr_error(n_fault), .squash_next(), .irq_hold(),
		.mem_rd_en(), .mem_addr(), .mem_rd_valid, .mem_rd_data);
	initial forever #20 clock = ~clock;
	task wrap_up;
		$display("errors %0d of %0d compares", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			wrap_up;
		end
	end
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	// called at a falling edge; returns one edge after the take
	task issue(input logic [15:0] w);
		instr_valid = 1'h1;
		instr = w;
		@(negedge clock);
	endtask
	task t_jump;
		far.gpr[5] = 64'h1003;
		far.gpr[6] = 64'h2002;
		issue({MAJ_COMPACT_GROUP, 5'h05, SUB_JUMP_REG});
		chk(redirect_pc, 64'h1002);
		chk(64'({instr_set_mode_bit, fetch_addr_error, squash_next}), 64'h5);
		chk(64'({n_mode, n_fault}), 64'h2);
		issue({MAJ_COMPACT_GROUP, 5'h06, SUB_JUMP_REG});
		chk(redirect_pc, 64'h2002);
		chk(64'({instr_set_mode_bit, fetch_addr_error}), 64'h1);
		chk(64'({n_mode, n_fault}), 64'h3);
		chk(n_redirect_pc, 64'h2002);
		instr_valid = 1'h0;
		@(negedge clock);
	endtask
	task t_link;
		config_instr_set_field = CFG_COMPRESSED_ONLY;
		far.gpr[7] = 64'h4001;
		instr_pc = 64'h100;
		issue({MAJ_COMPACT_GROUP, 5'h07, SUB_JUMP_LINK});
		chk(redirect_pc, 64'h4001);
		chk(rf_wr_data, 64'h102);
		instr_valid = 1'h0;
		config_instr_set_field = 2'h0;
		@(negedge clock);
	endtask
	task t_stack;
		far.gpr[29] = 64'hFFFF_FFFF_FFFF_FFF0;
		issue({MAJ_COMPACT_GROUP, 5'h1F, SUB_JUMP_STACK});
		chk(rf_wr_data, 64'h6C);
		chk(redirect_pc, 64'h2);
		chk(64'({redirect, irq_hold}), 64'h3);
		far.gpr[29] = 64'h7FFF_FFF0;
		issue({MAJ_COMPACT_GROUP, 5'h04, SUB_JUMP_STACK});
		chk(rf_wr_data, 64'hFFFF_FFFF_8000_0000);
		instr_valid = 1'h0;
		@(negedge clock);
	endtask
	task t_load;
		logic [63:0] ea;
		logic [7:0] ln;
		far.gpr[16] = 64'h1000;
		for (int i = 0; i < 4; i++) begin
			big_endian = i[1];
			reverse_endian = i[1];
			far.lat = i + 1;
			ea = i[0] ? 64'hFFF : 64'h100E;
			ln = {5'h0, ea[2:0] ^ {3{i[1]}}};
			issue({MAJ_BYTE_LOAD, 3'h7, 3'h0, i[0] ? 4'hF : 4'hE});
			instr_valid = 1'h0;
			chk(64'(instr_ready), 64'h0);
			chk(mem_addr, {ea[63:3], ea[2:0] ^ {3{i[1]}}});
			for (int k = 0; k < 20 && rf_wr_en !== 1'h1; k++) @(negedge clock);
			chk(64'(rf_wr_addr), 64'h7);
			chk(rf_wr_data, 64'(8'h11 * (ln + 8'h1)));
		end
	endtask
	initial begin
		far.gpr[31] = 64'h3;
		repeat (16) @(negedge clock);
		rst_n = 1'h1;
		t_jump;
		t_link;
		t_stack;
		t_load;
		wrap_up;
	end
endmodule
